// file: design/sgel_pkg.sv
// sgel_pkg: constants and types for the start guard and edit lock block.
// assumes a single 25 MHz control clock and a plain strobe register port.
package sgel_pkg;
	localparam int          NUM_SLOTS          = 6;
	localparam int          FUNC_W             = 5;
	localparam logic [4:0]  FUNC_GUARD         = 5'h0d;
	localparam logic [4:0]  FUNC_LOCK          = 5'h0f;
	localparam logic [4:0]  FUNC_CLEAR         = 5'h12;
	localparam logic [7:0]  ERR_GUARD          = 8'h0d;
	localparam logic [7:0]  ERR_NONE           = 8'h00;

	localparam logic [7:0]  OFS_SLOTS          = 8'h00;
	localparam logic [7:0]  OFS_CTRL           = 8'h04;
	localparam logic [7:0]  OFS_STATUS         = 8'h08;
	localparam logic [7:0]  OFS_MASK           = 8'h0c;
	localparam logic [7:0]  OFS_STATE          = 8'h10;
	localparam logic [7:0]  OFS_PARAM_BASE     = 8'h40;
	localparam logic [7:0]  OFS_PARAM_LAST     = 8'h7c;

	localparam int          PARAM_DEPTH        = 16;
	localparam int          PARAM_AW           = 4;
	localparam int          PARAM_W            = 16;
	localparam logic [3:0]  FREQ_IDX           = 4'h0;

	// slot 1 trip clear, slot 2 start guard, slot 3 edit lock, others unassigned
	localparam logic [29:0] SLOTS_RESET        = 30'h0000_3db2;
	localparam int          CTRL_SCOPE_BIT     = 0;
	localparam logic        CTRL_SCOPE_RESET   = 1'b0;

	localparam int          STAT_W             = 3;
	localparam int          STAT_GUARD_TRIP    = 0;
	localparam int          STAT_EDIT_REFUSED  = 1;
	localparam int          STAT_TRIP_CLEARED  = 2;
	localparam logic [2:0]  STAT_RESET         = 3'h0;
	localparam logic [2:0]  MASK_RESET         = 3'h0;

	localparam int          ST_STATE_LSB       = 0;
	localparam int          ST_MOTOR_BIT       = 2;
	localparam int          ST_ALARM_BIT       = 3;
	localparam int          ST_LOCK_BIT        = 4;
	localparam int          ST_GUARD_BIT       = 5;
	localparam int          ST_ERR_LSB         = 8;

	localparam logic [1:0]  SETTLE_CYC         = 2'h3;
	localparam int          CLK_HZ             = 25_000_000;
	localparam int          ALARM_CLEAR_MAX_MS = 30;

	typedef enum logic [1:0] {
		SGEL_POWERUP,
		SGEL_STOP,
		SGEL_RUN,
		SGEL_TRIP
	} sgel_state_type;
endpackage

// file: design/sgel_start_guard_edit_lock.sv
// sgel_start_guard_edit_lock: unattended start guard and parameter edit lock.
// assumes terminals are raw asynchronous levels; keypad and edit requests are
// one-cycle pulses synchronous to clk; sys_rst is the power-up reset.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module sgel_start_guard_edit_lock
	import sgel_pkg::*;
#(
	parameter int ALARM_CLEAR_MAX_CYC = ALARM_CLEAR_MAX_MS * (CLK_HZ / 1000)
) (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic                 ce,
	input  wire logic [NUM_SLOTS-1:0] term_in,
	input  wire logic                 run_cmd_in,
	input  wire logic                 keypad_reset,
	input  wire logic                 edit_req,
	input  wire logic                 edit_remote,
	input  wire logic [PARAM_AW-1:0]  edit_addr,
	input  wire logic [PARAM_W-1:0]   edit_data,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_we,
	input  wire logic                 reg_re,
	output logic      [31:0]          reg_rdata,
	output logic                      motor_run,
	output logic                      alarm_out,
	output logic      [7:0]           error_code,
	output logic                      edit_done,
	output logic                      edit_refused,
	output logic                      lock_active,
	output logic                      irq
);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || !ce);

	// synchronisers: s1 feeds s2 only, s3 is the edge reference
	logic [NUM_SLOTS-1:0] term_s1_reg, term_s2_reg, term_s3_reg;
	logic                 run_s1_reg, run_s2_reg, run_s3_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			term_s1_reg <= '0;
			term_s2_reg <= '0;
			term_s3_reg <= '0;
			run_s1_reg  <= 1'b0;
			run_s2_reg  <= 1'b0;
			run_s3_reg  <= 1'b0;
		end else if (ce) begin
			term_s1_reg <= term_in;
			term_s2_reg <= term_s1_reg;
			term_s3_reg <= term_s2_reg;
			run_s1_reg  <= run_cmd_in;
			run_s2_reg  <= run_s1_reg;
			run_s3_reg  <= run_s2_reg;
		end
	end

	// slot decode
	logic [29:0]          slots_reg, slots_next;
	logic                 scope_reg, scope_next;
	logic [NUM_SLOTS-1:0] guard_hits, lock_hits, clear_hits;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
			logic [FUNC_W-1:0] func;
			assign func           = slots_reg[gi*FUNC_W +: FUNC_W];
			assign guard_hits[gi] = (func == FUNC_GUARD) && term_s2_reg[gi];
			assign lock_hits[gi]  = (func == FUNC_LOCK) && term_s2_reg[gi];
			assign clear_hits[gi] = (func == FUNC_CLEAR) && term_s2_reg[gi] && !term_s3_reg[gi];
		end
	endgenerate

	logic guard_armed, lock_on, reset_pulse, run_rise;
	assign guard_armed = |guard_hits;
	assign lock_on     = |lock_hits;
	// acting on the onset keeps the clear far inside its deadline; pulse width is the host's concern
	assign reset_pulse = (|clear_hits) || keypad_reset;
	assign run_rise    = run_s2_reg && !run_s3_reg;

	// run / trip state machine
	sgel_state_type state_reg, state_next;
	logic [1:0]     settle_reg, settle_next;
	logic           motor_reg, motor_next;
	logic [7:0]     err_reg, err_next;
	logic           ev_trip, ev_cleared;

	always_comb begin
		state_next  = state_reg;
		settle_next = settle_reg;
		motor_next  = motor_reg;
		err_next    = err_reg;
		ev_trip     = 1'b0;
		ev_cleared  = 1'b0;
		case (state_reg)
			SGEL_POWERUP: begin
				// wait until the synchronisers hold real terminal levels
				if (settle_reg != SETTLE_CYC) begin
					settle_next = settle_reg + 2'h1;
				end else if (run_s2_reg && guard_armed) begin
					state_next = SGEL_TRIP;
					motor_next = 1'b0;
					err_next   = ERR_GUARD;
					ev_trip    = 1'b1;
				end else if (run_s2_reg) begin
					state_next = SGEL_RUN;
					motor_next = 1'b1;
				end else begin
					state_next = SGEL_STOP;
				end
			end
			SGEL_STOP: begin
				if (run_rise) begin
					state_next = SGEL_RUN;
					motor_next = 1'b1;
				end
			end
			SGEL_RUN: begin
				if (!run_s2_reg) begin
					state_next = SGEL_STOP;
					motor_next = 1'b0;
				end
			end
			SGEL_TRIP: begin
				motor_next = 1'b0;
				// a reset with run still high waits for a fresh run edge
				if (!run_s2_reg || reset_pulse) begin
					state_next = SGEL_STOP;
					err_next   = ERR_NONE;
					ev_cleared = 1'b1;
				end
			end
			default: begin
				state_next = SGEL_STOP;
				motor_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg  <= SGEL_POWERUP;
			settle_reg <= 2'h0;
			motor_reg  <= 1'b0;
			err_reg    <= ERR_NONE;
		end else if (ce) begin
			state_reg  <= state_next;
			settle_reg <= settle_next;
			motor_reg  <= motor_next;
			err_reg    <= err_next;
		end
	end

	// parameter edits; keypad and remote share one gate on purpose
	logic [PARAM_W-1:0] param_mem [PARAM_DEPTH];
	logic               edit_ok, edit_bad;
	logic               done_reg, done_next, refused_reg, refused_next;

	always_comb begin
		edit_ok = 1'b0;
		if (edit_req) begin
			if (!lock_on) begin
				edit_ok = 1'b1;
			end else if (edit_addr == FREQ_IDX) begin
				edit_ok = !scope_reg;
			end else begin
				edit_ok = 1'b0;
			end
		end
		edit_bad     = edit_req && !edit_ok;
		done_next    = edit_ok;
		refused_next = edit_bad;
	end

	always_ff @(posedge clk) begin
		if (ce && edit_ok) begin
			param_mem[edit_addr] <= edit_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			done_reg    <= 1'b0;
			refused_reg <= 1'b0;
		end else if (ce) begin
			done_reg    <= done_next;
			refused_reg <= refused_next;
		end
	end

	// register port, status and interrupt
	logic [STAT_W-1:0] status_reg, status_next, mask_reg, mask_next, stat_set, stat_clr;
	logic [31:0]       rdata_reg, rdata_next;
	logic [31:0]       state_word;
	logic              param_hit;

	assign param_hit = (reg_addr >= OFS_PARAM_BASE) && (reg_addr <= OFS_PARAM_LAST) && (reg_addr[1:0] == 2'h0);

	always_comb begin
		state_word = '0;
		state_word[ST_STATE_LSB +: 2] = state_reg;
		state_word[ST_MOTOR_BIT]      = motor_reg;
		state_word[ST_ALARM_BIT]      = (state_reg == SGEL_TRIP);
		state_word[ST_LOCK_BIT]       = lock_on;
		state_word[ST_GUARD_BIT]      = guard_armed;
		state_word[ST_ERR_LSB +: 8]   = err_reg;
	end

	always_comb begin
		slots_next = slots_reg;
		scope_next = scope_reg;
		mask_next  = mask_reg;
		stat_clr   = '0;
		stat_set   = '0;
		stat_set[STAT_GUARD_TRIP]   = ev_trip;
		stat_set[STAT_EDIT_REFUSED] = edit_bad;
		stat_set[STAT_TRIP_CLEARED] = ev_cleared;
		if (reg_we) begin
			case (reg_addr)
				OFS_SLOTS:  slots_next = reg_wdata[29:0];
				OFS_CTRL:   scope_next = reg_wdata[CTRL_SCOPE_BIT];
				OFS_STATUS: stat_clr   = reg_wdata[STAT_W-1:0];
				OFS_MASK:   mask_next  = reg_wdata[STAT_W-1:0];
				default:    slots_next = slots_reg;
			endcase
		end
		// a new event beats a write-one clear in the same cycle
		status_next = (status_reg & ~stat_clr) | stat_set;
		rdata_next  = '0;
		if (reg_re) begin
			case (reg_addr)
				OFS_SLOTS:  rdata_next = {2'h0, slots_reg};
				OFS_CTRL:   rdata_next = {31'h0000_0000, scope_reg};
				OFS_STATUS: rdata_next = {29'h0000_0000, status_reg};
				OFS_MASK:   rdata_next = {29'h0000_0000, mask_reg};
				OFS_STATE:  rdata_next = state_word;
				default: begin
					if (param_hit) begin
						rdata_next = {16'h0000, param_mem[reg_addr[5:2]]};
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slots_reg  <= SLOTS_RESET;
			scope_reg  <= CTRL_SCOPE_RESET;
			status_reg <= STAT_RESET;
			mask_reg   <= MASK_RESET;
			rdata_reg  <= 32'h0000_0000;
		end else if (ce) begin
			slots_reg  <= slots_next;
			scope_reg  <= scope_next;
			status_reg <= status_next;
			mask_reg   <= mask_next;
			rdata_reg  <= rdata_next;
		end
	end

	assign reg_rdata    = rdata_reg;
	assign motor_run    = motor_reg;
	assign alarm_out    = (state_reg == SGEL_TRIP);
	assign error_code   = err_reg;
	assign edit_done    = done_reg;
	assign edit_refused = refused_reg;
	assign lock_active  = lock_on;
	assign irq          = |(status_reg & mask_reg);

	// checks
	logic [19:0] alarm_age_reg;
	always_ff @(posedge clk) begin
		if (sys_rst || !alarm_out) begin
			alarm_age_reg <= 20'h0_0000;
		end else if (ce && (reset_pulse || alarm_age_reg != 20'h0_0000)) begin
			alarm_age_reg <= alarm_age_reg + 20'h0_0001;
		end
	end

	AST_GUARD_TRIP: assert property (
		(state_reg == SGEL_POWERUP && settle_reg == SETTLE_CYC && run_s2_reg && guard_armed)
		|=> (alarm_out && !motor_run && error_code == ERR_GUARD))
		else $error("guarded power-up run did not trip");
	AST_NO_MOTOR_IN_TRIP: assert property (
		alarm_out |-> !motor_run)
		else $error("motor output on during guard trip");
	AST_CLEAR_RUN_OFF: assert property (
		(alarm_out && !run_s2_reg) |=> (state_reg == SGEL_STOP && error_code == ERR_NONE))
		else $error("trip not cleared by run going off");
	AST_CLEAR_RESET: assert property (
		(alarm_out && reset_pulse) |=> !alarm_out ##0 !motor_run)
		else $error("trip not cleared by reset");
	AST_NEW_START: assert property (
		(state_reg == SGEL_STOP && run_rise) |=> motor_run)
		else $error("new run edge did not start motor");
	AST_RESUME: assert property (
		(state_reg == SGEL_POWERUP && settle_reg == SETTLE_CYC && run_s2_reg && !guard_armed)
		|=> (motor_run && !alarm_out))
		else $error("unguarded run not resumed at power-up");
	AST_LOCK_REFUSE: assert property (
		(edit_req && lock_on && edit_addr != FREQ_IDX) |=> (edit_refused && !edit_done))
		else $error("locked edit was not refused");
	AST_UNLOCK_STORE: assert property (
		(edit_req && !lock_on) |=> (edit_done && param_mem[$past(edit_addr)] == $past(edit_data)))
		else $error("unlocked edit not stored");
	AST_SCOPE: assert property (
		(edit_req && lock_on && edit_addr == FREQ_IDX) |=> (edit_done == !$past(scope_reg)))
		else $error("frequency edit ignores lock scope");
	AST_LOCK_ALL: assert property (
		(edit_req && lock_on && scope_reg) |=> edit_refused)
		else $error("full lock let an edit through");
	AST_ALARM_DEADLINE: assert property (
		alarm_age_reg < ALARM_CLEAR_MAX_CYC)
		else $error("alarm outlived reset deadline");
	AST_SYNC_DELAY: assert property (
		$past(ce) |-> (term_s2_reg == $past(term_s1_reg)))
		else $error("terminal synchroniser skipped a stage");

	COV_GUARD_TRIP: cover property (state_reg == SGEL_POWERUP ##1 alarm_out);
	COV_RESET_RESTART: cover property (alarm_out && reset_pulse ##1 state_reg == SGEL_STOP ##[1:20] motor_run);
	COV_RESUME: cover property (state_reg == SGEL_POWERUP ##1 motor_run);
	COV_REFUSED: cover property (edit_refused && edit_remote == 1'b0);

endmodule // sgel_start_guard_edit_lock

// file: test/sgel_operator_model.sv
// sgel_operator_model: input terminals and keypad in front of the block.
// assumes slot 1 is trip clear, slot 2 start guard, slot 3 edit lock (reset map).
`timescale 1ns/1ps
module sgel_operator_model
	import sgel_pkg::*;
#(
	parameter int CLEAR_HOLD_CYC = 20,
	parameter int START_WAIT_CYC = 30
) (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	output logic      [NUM_SLOTS-1:0] term_in,
	output logic                      run_cmd_in,
	output logic                      keypad_reset
);
	int up_cnt = 0;

	initial begin
		term_in      = '0;
		run_cmd_in   = 1'b0;
		keypad_reset = 1'b0;
	end

	always @(posedge clk) begin
		up_cnt <= sys_rst ? 0 : up_cnt + 1;
	end

	task automatic set_pins(input logic run, input logic [NUM_SLOTS-1:0] t);
		@(posedge clk);
		run_cmd_in <= run;
		term_in    <= t;
	endtask

	// counts shortened from seconds so the run stays short
	task automatic start_run;
		while (up_cnt < START_WAIT_CYC) @(posedge clk);
		@(posedge clk);
		run_cmd_in <= 1'b1;
	endtask

	task automatic pulse_clear;
		@(posedge clk);
		term_in[0] <= 1'b1;
		repeat (CLEAR_HOLD_CYC) @(posedge clk);
		term_in[0] <= 1'b0;
	endtask

	task automatic press_reset;
		@(posedge clk);
		keypad_reset <= 1'b1;
		@(posedge clk);
		keypad_reset <= 1'b0;
	endtask
endmodule // sgel_operator_model

// file: test/sgel_start_guard_edit_lock_tb.sv
// sgel_start_guard_edit_lock_tb: self-checking bench for the guard and lock block.
// assumes the operator model drives terminals; bench drives edits and registers.
`timescale 1ns/1ps
module sgel_start_guard_edit_lock_tb;
	import sgel_pkg::*;
	logic                 clk = 1'b0;
	logic                 sys_rst = 1'b1;
	logic                 ce = 1'b1;
	logic                 edit_req = 1'b0;
	logic                 edit_remote = 1'b0;
	logic [PARAM_AW-1:0]  edit_addr = '0;
	logic [PARAM_W-1:0]   edit_data = '0;
	logic [7:0]           reg_addr = '0;
	logic [31:0]          reg_wdata = '0;
	logic                 reg_we = 1'b0;
	logic                 reg_re = 1'b0;
	logic [31:0]          reg_rdata;
	logic                 motor_run, alarm_out, edit_done, edit_refused, lock_active, irq, run_cmd_in, keypad_reset;
	logic [7:0]           error_code;
	logic [NUM_SLOTS-1:0] term_in;
	logic [31:0]          rd;
	logic [15:0]          pmem [16];
	int                   n_errors = 0;
	int                   checks = 0;
	int                   seed = 32'h0000_0599;

	always #20 clk = ~clk;

	sgel_operator_model op (.clk(clk), .sys_rst(sys_rst), .term_in(term_in), .run_cmd_in(run_cmd_in),
		.keypad_reset(keypad_reset));

	sgel_start_guard_edit_lock #(.ALARM_CLEAR_MAX_CYC(50)) uut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.term_in(term_in), .run_cmd_in(run_cmd_in), .keypad_reset(keypad_reset), .edit_req(edit_req),
		.edit_remote(edit_remote), .edit_addr(edit_addr), .edit_data(edit_data), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .motor_run(motor_run),
		.alarm_out(alarm_out), .error_code(error_code), .edit_done(edit_done), .edit_refused(edit_refused),
		.lock_active(lock_active), .irq(irq));

	task automatic final_report;
		if (n_errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_we    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		reg_re   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	// bounded wait on motor_run (sel 0) or alarm_out (sel 1)
	task automatic wait_out(input bit sel, input logic v);
		int i;
		for (i = 0; i < 60; i++) begin
			@(posedge clk);
			#1;
			if ((sel ? alarm_out : motor_run) === v) break;
		end
		if (i == 60) begin
			n_errors++;
			$display("CHECK FAILED t=%0t output wait timed out", $time);
			final_report();
		end
	endtask

	task automatic power_up(input logic run, input logic [NUM_SLOTS-1:0] t);
		op.set_pins(run, t);
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
	endtask

	task automatic edit(input logic [3:0] a, input logic [15:0] d, input logic r, input logic ok);
		@(posedge clk);
		edit_req    <= 1'b1;
		edit_addr   <= a;
		edit_data   <= d;
		edit_remote <= r;
		@(posedge clk);
		edit_req <= 1'b0;
		#1;
		chk(edit_done, ok, "edit done");
		chk(edit_refused, !ok, "edit refused");
		if (ok) pmem[a] = d;
		rd_reg(OFS_PARAM_BASE + {2'b00, a, 2'b00});
		chk(rd, {16'h0000, pmem[a]}, "param word");
	endtask

	initial begin
		logic [15:0] rv;
		power_up(1'b1, 6'h02);
		wait_out(1'b1, 1'b1);
		chk(motor_run, 1'b0, "motor in trip");
		chk(error_code, ERR_GUARD, "error code");
		rd_reg(OFS_STATE);
		chk(rd, {16'h0000, ERR_GUARD, 8'h2b}, "state word");
		rd_reg(OFS_SLOTS);
		chk(rd, {2'b00, SLOTS_RESET}, "slot map");
		wr(OFS_MASK, 32'h0000_0007);
		@(posedge clk);
		#1 chk(irq, 1'b1, "irq raised");
		op.press_reset();
		wait_out(1'b1, 1'b0);
		chk(error_code, ERR_NONE, "error cleared");
		chk(motor_run, 1'b0, "no start on held run");
		op.set_pins(1'b0, 6'h02);
		repeat (4) @(posedge clk);
		op.start_run();
		wait_out(1'b0, 1'b1);
		rd_reg(OFS_STATUS);
		chk(rd, 32'h0000_0005, "status trip and clear");
		wr(OFS_STATUS, 32'h0000_0005);
		rd_reg(OFS_STATUS);
		chk(rd, 32'h0000_0000, "status cleared");
		chk(irq, 1'b0, "irq cleared");
		rd_reg(8'h20);
		chk(rd, 32'h0000_0000, "unmapped read");
		power_up(1'b1, 6'h02);
		wait_out(1'b1, 1'b1);
		op.set_pins(1'b0, 6'h02);
		wait_out(1'b1, 1'b0);
		power_up(1'b1, 6'h02);
		wait_out(1'b1, 1'b1);
		fork
			op.pulse_clear();
			wait_out(1'b1, 1'b0);
		join
		chk(motor_run, 1'b0, "held run after clear");
		power_up(1'b1, 6'h00);
		wait_out(1'b0, 1'b1);
		chk(alarm_out, 1'b0, "no alarm unguarded");
		// clock enable low must freeze the synchronisers and the run state
		@(posedge clk);
		ce <= 1'b0;
		op.set_pins(1'b0, 6'h00);
		repeat (6) @(posedge clk);
		#1 chk(motor_run, 1'b1, "state moved while clock enable low");
		@(posedge clk);
		ce <= 1'b1;
		wait_out(1'b0, 1'b0);
		power_up(1'b0, 6'h00);
		for (int i = 0; i < 16; i++) begin
			rv = 16'($random(seed));
			edit(i[3:0], rv, i[0], 1'b1);
		end
		op.set_pins(1'b0, 6'h04);
		repeat (4) @(posedge clk);
		#1 chk(lock_active, 1'b1, "lock active");
		for (int r = 0; r < 2; r++) begin
			rv = 16'($random(seed));
			edit(4'(1 + ($unsigned($random(seed)) % 15)), rv, r[0], 1'b0);
		end
		rv = 16'($random(seed));
		edit(FREQ_IDX, rv, 1'b0, 1'b1);
		wr(OFS_CTRL, 32'h0000_0001);
		rv = 16'($random(seed));
		edit(FREQ_IDX, rv, 1'b1, 1'b0);
		rd_reg(OFS_STATUS);
		chk(rd & 32'h0000_0002, 32'h0000_0002, "refusal status");
		op.set_pins(1'b0, 6'h00);
		repeat (4) @(posedge clk);
		rv = 16'($random(seed));
		edit(4'h5, rv, 1'b1, 1'b1);
		final_report();
	end
endmodule // sgel_start_guard_edit_lock_tb
